// >>> ssu_pkg.sv
// Shared constants and types of the switch status upper fields block
`default_nettype none
package ssu_pkg;

    // ************************************************************
    // Bus constants
    // ************************************************************
    localparam int unsigned DATA_W       = 32;
    localparam logic [29:0] STATUS_IDX   = 30'h0000_0000;
    localparam logic [2:0]  HSIZE_WORD   = 3'h2;
    localparam logic        HRESP_OKAY   = 1'h0;
    localparam logic [31:0] RDATA_IDLE   = 32'h0000_0000;

    // ************************************************************
    // Field reset values and codes
    // ************************************************************
    localparam int unsigned STRAP_N      = 3;
    localparam logic [2:0]  STRAP_RST    = 3'h0;
    localparam logic [3:0]  MARKER_RST   = 4'h0;
    localparam logic [3:0]  RSVD_VAL     = 4'h0;
    localparam logic [16:0] LOW_VAL      = 17'h0_0000;
    localparam logic [3:0]  LOCK_NONE    = 4'h0;
    localparam logic [3:0]  LOCK_MIN     = 4'h1;
    localparam logic [3:0]  LOCK_MAX     = 4'hE;

    // ************************************************************
    // Strap capture timing
    // ************************************************************
    localparam logic [2:0]  CAPT_RST     = 3'h0;
    localparam logic [2:0]  CAPT_LAST    = 3'h5;
    localparam logic [2:0]  CAPT_STEP    = 3'h1;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [0:0] {
        SSU_PH_CAPTURE = 1'b0,
        SSU_PH_RUN     = 1'b1
    } ssu_phase_e;

    // Lock field widened to 23:20 so code 0xE fits
    typedef struct packed {
        logic [3:0]  marker;
        logic [3:0]  rsvd;
        logic [3:0]  lock;
        logic [2:0]  join_strap;
        logic [16:0] low;
    } ssu_status_s;

    typedef struct packed {
        logic       sel;
        logic [1:0] trans;
        logic       write;
        logic [2:0] size;
        logic       ready;
    } ssu_ahb_ctl_s;

endpackage
`default_nettype wire

// >>> ssu_strap_sync.sv
// Three-stage synchroniser with agreement filter for strap pins
`timescale 1ns/1ps
`default_nettype none
module ssu_strap_sync #(
    parameter int unsigned W = 3
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] pin_i,
    output var  logic [W-1:0] level_o
);

    if (W < 1) begin : g_chk
        $error("ssu_strap_sync: W must be at least 1");
    end

    for (genvar g = 0; g < W; g++) begin : g_bit
        logic s1_reg;
        logic s2_reg;
        logic s3_reg;
        logic filt_reg;
        logic filt_next;

        // Level counts only once stages two and three agree
        always_comb begin
            filt_next = filt_reg;
            if (s2_reg == s3_reg) begin
                filt_next = s3_reg;
            end
        end

        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                s1_reg   <= 1'b0;
                s2_reg   <= 1'b0;
                s3_reg   <= 1'b0;
                filt_reg <= 1'b0;
            end else begin
                s1_reg   <= pin_i[g];
                s2_reg   <= s1_reg;
                s3_reg   <= s2_reg;
                filt_reg <= filt_next;
            end
        end

        assign level_o[g] = filt_reg;
    end

endmodule // ssu_strap_sync
`default_nettype wire

// >>> ssu_ahb_if.sv
// AHB-Lite address phase decode for the switch status register
`timescale 1ns/1ps
`default_nettype none
module ssu_ahb_if #(
    parameter int unsigned ADDR_W = 12
) (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire ssu_pkg::ssu_ahb_ctl_s ctl_i,
    input  wire logic [ADDR_W-1:0]   haddr_i,
    output var  logic                rd_take_o,
    output var  logic                wr_pend_o,
    output var  logic                hreadyout_o,
    output var  logic                hresp_o
);

    if (ADDR_W < 3 || ADDR_W > 32) begin : g_chk
        $error("ssu_ahb_if: ADDR_W must lie in 3..32");
    end

    logic hit;
    logic wr_pend_reg;
    logic wr_pend_next;

    // Non-word sizes and other addresses are ignored, still OKAY
    always_comb begin
        hit = ctl_i.sel && ctl_i.trans[1] && ctl_i.ready
            && (ctl_i.size == ssu_pkg::HSIZE_WORD)
            && (haddr_i[ADDR_W-1:2]
                == ssu_pkg::STATUS_IDX[ADDR_W-3:0]);
        wr_pend_next = hit && ctl_i.write;
        rd_take_o    = hit && !ctl_i.write;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_pend_reg <= 1'b0;
            hreadyout_o <= 1'b1;
            hresp_o     <= ssu_pkg::HRESP_OKAY;
        end else begin
            wr_pend_reg <= wr_pend_next;
            hreadyout_o <= 1'b1;
            hresp_o     <= ssu_pkg::HRESP_OKAY;
        end
    end

    assign wr_pend_o = wr_pend_reg;

endmodule // ssu_ahb_if
`default_nettype wire

// >>> ssu_switch_status.sv
// Upper fields of the switch status register behind AHB-Lite
//
// The AHB-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ssu_switch_status #(
    parameter int unsigned ADDR_W = 12
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              hot_reset_i,
    input  wire logic              pair10_11_join_strap_i,
    input  wire logic              pair12_13_join_strap_i,
    input  wire logic              pair14_15_join_strap_i,
    input  wire logic              lock_active_i,
    input  wire logic [3:0]        lock_port_i,
    input  wire logic              hsel_i,
    input  wire logic [ADDR_W-1:0] haddr_i,
    input  wire logic [1:0]        htrans_i,
    input  wire logic              hwrite_i,
    input  wire logic [2:0]        hsize_i,
    input  wire logic              hready_i,
    input  wire logic [31:0]       hwdata_i,
    output var  logic [31:0]       hrdata_o,
    output var  logic              hreadyout_o,
    output var  logic              hresp_o,
    output var  logic [2:0]        join_strap_o
);

    if (ADDR_W < 3 || ADDR_W > 32) begin : g_chk
        $error("ssu_switch_status: ADDR_W must lie in 3..32");
    end

    // ************************************************************
    // Bus front end
    // ************************************************************
    ssu_pkg::ssu_ahb_ctl_s ahb_ctl;
    logic                  rd_take;
    logic                  wr_pend;

    assign ahb_ctl = '{sel:   hsel_i,
                       trans: htrans_i,
                       write: hwrite_i,
                       size:  hsize_i,
                       ready: hready_i};

    ssu_ahb_if #(
        .ADDR_W (ADDR_W)
    ) u_ahb (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .ctl_i       (ahb_ctl),
        .haddr_i     (haddr_i),
        .rd_take_o   (rd_take),
        .wr_pend_o   (wr_pend),
        .hreadyout_o (hreadyout_o),
        .hresp_o     (hresp_o)
    );

    // ************************************************************
    // Strap synchronisers
    // ************************************************************
    logic [2:0] strap_pin;
    logic [2:0] strap_lvl;

    assign strap_pin = {pair14_15_join_strap_i,
                        pair12_13_join_strap_i,
                        pair10_11_join_strap_i};

    ssu_strap_sync #(
        .W (ssu_pkg::STRAP_N)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (strap_pin),
        .level_o (strap_lvl)
    );

    // ************************************************************
    // Strap capture after fundamental reset
    // ************************************************************
    // Async reset may not load a pin, so the straps are taken
    // in the first cycles after release, once the filter has
    // settled, then frozen until the next fundamental reset.
    ssu_pkg::ssu_phase_e phase_reg;
    ssu_pkg::ssu_phase_e phase_next;
    logic [2:0]          cnt_reg;
    logic [2:0]          cnt_next;
    logic [2:0]          strap_reg;
    logic [2:0]          strap_next;

    always_comb begin
        phase_next = phase_reg;
        cnt_next   = cnt_reg;
        strap_next = strap_reg;
        unique case (phase_reg)
            ssu_pkg::SSU_PH_CAPTURE: begin
                strap_next = strap_lvl;
                if (cnt_reg == ssu_pkg::CAPT_LAST) begin
                    phase_next = ssu_pkg::SSU_PH_RUN;
                end else begin
                    cnt_next = cnt_reg + ssu_pkg::CAPT_STEP;
                end
            end
            ssu_pkg::SSU_PH_RUN: begin
                strap_next = strap_reg;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            phase_reg <= ssu_pkg::SSU_PH_CAPTURE;
            cnt_reg   <= ssu_pkg::CAPT_RST;
            strap_reg <= ssu_pkg::STRAP_RST;
        end else begin
            phase_reg <= phase_next;
            cnt_reg   <= cnt_next;
            strap_reg <= strap_next;
        end
    end

    // ************************************************************
    // Lock state mirror
    // ************************************************************
    logic [3:0] lock_reg;
    logic [3:0] lock_next;
    logic       lock_ok;

    always_comb begin
        lock_ok = (lock_port_i >= ssu_pkg::LOCK_MIN)
               && (lock_port_i <= ssu_pkg::LOCK_MAX);
        lock_next = ssu_pkg::LOCK_NONE;
        if (lock_active_i && lock_ok && !hot_reset_i) begin
            lock_next = lock_port_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            lock_reg <= ssu_pkg::LOCK_NONE;
        end else begin
            lock_reg <= lock_next;
        end
    end

    // ************************************************************
    // Marker and read data
    // ************************************************************
    ssu_pkg::ssu_status_s wdata_s;
    ssu_pkg::ssu_status_s rd_s;
    logic [3:0]           marker_reg;
    logic [3:0]           marker_next;
    logic [3:0]           marker_now;
    logic [31:0]          rdata_next;
    logic [2:0]           join_next;

    assign wdata_s = hwdata_i;

    always_comb begin
        marker_next = marker_reg;
        if (wr_pend) begin
            marker_next = wdata_s.marker;
        end
        // A read right behind a write sees the new marker
        marker_now = wr_pend ? wdata_s.marker : marker_reg;
        rd_s = '{marker:     marker_now,
                 rsvd:       ssu_pkg::RSVD_VAL,
                 lock:       lock_reg,
                 join_strap: strap_reg,
                 low:        ssu_pkg::LOW_VAL};
        rdata_next = ssu_pkg::RDATA_IDLE;
        if (rd_take) begin
            rdata_next = rd_s;
        end
        join_next = strap_reg;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            marker_reg   <= ssu_pkg::MARKER_RST;
            hrdata_o     <= ssu_pkg::RDATA_IDLE;
            join_strap_o <= ssu_pkg::STRAP_RST;
        end else begin
            marker_reg   <= marker_next;
            hrdata_o     <= rdata_next;
            join_strap_o <= join_next;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_strap_track: assert property (
        phase_reg == ssu_pkg::SSU_PH_CAPTURE
        |=> strap_reg == $past(strap_lvl))
        else $error("strap not tracked during capture");

    a_strap_frozen: assert property (
        phase_reg == ssu_pkg::SSU_PH_RUN
        |=> $stable(strap_reg) && $stable(phase_reg))
        else $error("strap changed after capture");

    a_strap_visible: assert property (
        rd_take |=> hrdata_o[19:17] == $past(strap_reg))
        else $error("strap bits misplaced in read data");

    a_capture_len: assert property (
        $rose(phase_reg == ssu_pkg::SSU_PH_RUN)
        |-> $past(cnt_reg) == ssu_pkg::CAPT_LAST)
        else $error("capture window length wrong");

    a_lock_idle: assert property (
        !lock_active_i ##1 rd_take |=> hrdata_o[23:20] == 4'h0)
        else $error("lock field not zero when unlocked");

    a_lock_port: assert property (
        lock_active_i && lock_ok && !hot_reset_i
        |=> lock_reg == $past(lock_port_i))
        else $error("lock field not the locked port");

    a_marker_store: assert property (
        wr_pend ##1 (rd_take && !wr_pend)
        |=> (hrdata_o >> 28) == ($past(hwdata_i, 2) >> 28))
        else $error("marker write not read back");

    a_marker_keep: assert property (
        hot_reset_i && !wr_pend |=> $stable(marker_reg))
        else $error("marker disturbed by hot reset");

    a_lock_range: assert property (
        rd_take |=> hrdata_o[23:20] <= 4'hE
                    && hrdata_o[23:20] == $past(lock_reg))
        else $error("lock field out of range");

    a_rsvd_zero: assert property (
        rd_take |=> hrdata_o[27:24] == 4'h0
                    && hrdata_o[16:0] == 17'h0_0000)
        else $error("reserved bits not zero");

    a_bus_okay: assert property (
        hreadyout_o && (hresp_o == ssu_pkg::HRESP_OKAY))
        else $error("bus not ready or response not OKAY");

    // Idle zero keeps stale words off a shared read bus
    a_rdata_idle: assert property (
        !rd_take |=> hrdata_o == ssu_pkg::RDATA_IDLE)
        else $error("read data not zero outside a read");

    a_join_out: assert property (
        1'b1 |=> join_strap_o == $past(strap_reg))
        else $error("strap output does not follow register");

    a_capture_count: assert property (
        phase_reg == ssu_pkg::SSU_PH_CAPTURE
        && cnt_reg != ssu_pkg::CAPT_LAST
        |=> cnt_reg == $past(cnt_reg) + ssu_pkg::CAPT_STEP)
        else $error("capture counter skipped a step");

    a_cnt_hold: assert property (
        phase_reg == ssu_pkg::SSU_PH_RUN
        |-> cnt_reg == ssu_pkg::CAPT_LAST)
        else $error("capture counter moved after capture");

    a_lock_clear: assert property (
        !lock_active_i |=> lock_reg == ssu_pkg::LOCK_NONE)
        else $error("lock mirror not cleared when unlocked");

    a_hot_lock_zero: assert property (
        hot_reset_i |=> lock_reg == ssu_pkg::LOCK_NONE)
        else $error("lock mirror not cleared by hot reset");

    // Ports 0 and 15 are no valid lock partner
    a_lock_refused: assert property (
        lock_active_i && (lock_port_i == 4'h0 || lock_port_i == 4'hF)
        |=> lock_reg == ssu_pkg::LOCK_NONE)
        else $error("invalid lock port not read as zero");

    a_marker_hold: assert property (
        !wr_pend |=> $stable(marker_reg))
        else $error("marker changed without a write");

    a_wr_source: assert property (
        wr_pend |-> $past(hsel_i) && $past(hwrite_i) && $past(hready_i)
                    && $past(htrans_i) >= 2'h2)
        else $error("write pending without a write request");

    // ************************************************************
    // Coverage
    // ************************************************************
    c_lock_refused: cover property (lock_active_i && !lock_ok);
    c_capture_done: cover property (
        $rose(phase_reg == ssu_pkg::SSU_PH_RUN));
    c_write_read: cover property (wr_pend ##1 rd_take);
    c_locked_read: cover property (
        lock_active_i && lock_ok ##1 rd_take);
    c_hot_marker: cover property (
        hot_reset_i && marker_reg != 4'h0);

endmodule // ssu_switch_status
`default_nettype wire

// >>> test_switch_status_upper_fields.sv
// Self-checking bench for the switch status upper fields block
`timescale 1ns/1ps
`default_nettype none
module test_switch_status_upper_fields;

    // ************************************************************
    // Signals
    // ************************************************************
    localparam int unsigned ADDR_W = 12;
    // Tests need under two hundred cycles; ceiling leaves wide margin
    localparam int          LIMIT  = 5000;

    logic              clk_i;
    logic              rst_i;
    logic              hot_reset_i;
    logic [2:0]        strap_pins;
    logic              lock_active_i;
    logic [3:0]        lock_port_i;
    logic              hsel_i;
    logic [ADDR_W-1:0] haddr_i;
    logic [1:0]        htrans_i;
    logic              hwrite_i;
    logic [2:0]        hsize_i;
    logic [31:0]       hwdata_i;
    logic [31:0]       hrdata_o;
    logic              hreadyout_o;
    logic              hresp_o;
    logic [2:0]        join_strap_o;
    wire  logic        hready;
    logic [31:0]       rd;
    logic [3:0]        mk [4] = '{4'hF, 4'h5, 4'hA, 4'h6};
    int                fail_count = 0;
    int                check_count = 0;
    int                cycles = 0;

    // Single slave: its ready is the bus ready
    assign hready = hreadyout_o;

    ssu_switch_status #(
        .ADDR_W(ADDR_W)
    ) u_dut (
        .clk_i                 (clk_i),
        .rst_i                 (rst_i),
        .hot_reset_i           (hot_reset_i),
        .pair10_11_join_strap_i(strap_pins[0]),
        .pair12_13_join_strap_i(strap_pins[1]),
        .pair14_15_join_strap_i(strap_pins[2]),
        .lock_active_i         (lock_active_i),
        .lock_port_i           (lock_port_i),
        .hsel_i                (hsel_i),
        .haddr_i               (haddr_i),
        .htrans_i              (htrans_i),
        .hwrite_i              (hwrite_i),
        .hsize_i               (hsize_i),
        .hready_i              (hready),
        .hwdata_i              (hwdata_i),
        .hrdata_o              (hrdata_o),
        .hreadyout_o           (hreadyout_o),
        .hresp_o               (hresp_o),
        .join_strap_o          (join_strap_o)
    );

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [31:0] exp_word(input logic [3:0] mkv,
                                             input logic [3:0] lk,
                                             input logic [2:0] st);
        ssu_pkg::ssu_status_s s;
        s.marker     = mkv;
        s.rsvd       = ssu_pkg::RSVD_VAL;
        s.lock       = lk;
        s.join_strap = st;
        s.low        = ssu_pkg::LOW_VAL;
        return s;
    endfunction

    // Entered just after a rising edge; returns at the data edge
    task automatic xfer(input logic [ADDR_W-1:0] a, input logic w,
                        input logic [31:0] wd, output logic [31:0] rdat);
        hsel_i   <= 1'b1;
        haddr_i  <= a;
        htrans_i <= 2'b10;
        hwrite_i <= w;
        hsize_i  <= ssu_pkg::HSIZE_WORD;
        @(posedge clk_i);
        while (hready !== 1'b1) @(posedge clk_i);
        hsel_i   <= 1'b0;
        htrans_i <= 2'b00;
        hwdata_i <= wd;
        @(posedge clk_i);
        while (hready !== 1'b1) @(posedge clk_i);
        rdat = hrdata_o;
        chk("bus response", 32'h0000_0002, {30'h0, hready, hresp_o});
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        xfer(a, 1'b1, d, dummy);
    endtask

    task automatic rd_chk(input logic [ADDR_W-1:0] a,
                          input logic [31:0] exp, input string what);
        xfer(a, 1'b0, 32'h0000_0000, rd);
        chk(what, exp, rd);
    endtask

    task automatic summarize();
        if (fail_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ************************************************************
    // Clock and timeout
    // ************************************************************
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            fail_count++;
            summarize();
        end
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        rst_i         = 1'b1;
        hot_reset_i   = 1'b0;
        strap_pins    = 3'h5;
        lock_active_i = 1'b0;
        lock_port_i   = 4'h0;
        hsel_i        = 1'b0;
        haddr_i       = '0;
        htrans_i      = 2'h0;
        hwrite_i      = 1'b0;
        hsize_i       = 3'h0;
        hwdata_i      = 32'h0000_0000;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        // Straps held stable well past the capture window
        repeat (12) @(posedge clk_i);
        rd_chk(12'h000, exp_word(4'h0, 4'h0, 3'h5), "status");
        chk("join_strap_o", 32'h0000_0005, {29'h0, join_strap_o});
        // Pins move after capture: bits must stay frozen
        strap_pins <= 3'h2;
        repeat (12) @(posedge clk_i);
        rd_chk(12'h000, exp_word(4'h0, 4'h0, 3'h5), "strap");
        for (int p = 0; p < 16; p++) begin
            lock_active_i <= 1'b1;
            lock_port_i   <= 4'(p);
            repeat (2) @(posedge clk_i);
            rd_chk(12'h000, exp_word(4'h0,
                   (p >= 1 && p <= 14) ? 4'(p) : 4'h0, 3'h5),
                   "lock field");
        end
        lock_active_i <= 1'b0;
        lock_port_i   <= 4'h9;
        repeat (2) @(posedge clk_i);
        rd_chk(12'h000, exp_word(4'h0, 4'h0, 3'h5), "unlocked");
        foreach (mk[i]) begin
            wr(12'h000, {mk[i], 28'hFFF_FFFF});
            rd_chk(12'h000, exp_word(mk[i], 4'h0, 3'h5), "marker");
        end
        // Unmapped word: write dropped, read gives zero
        wr(12'h004, 32'h9000_0000);
        rd_chk(12'h004, 32'h0000_0000, "unmapped");
        rd_chk(12'h000, exp_word(4'h6, 4'h0, 3'h5), "marker kept");
        wr(12'h000, 32'hA000_0000);
        lock_active_i <= 1'b1;
        lock_port_i   <= 4'h7;
        repeat (2) @(posedge clk_i);
        hot_reset_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rd_chk(12'h000, exp_word(4'hA, 4'h0, 3'h5), "hot reset");
        hot_reset_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rd_chk(12'h000, exp_word(4'hA, 4'h7, 3'h5), "after hot");
        // Fundamental reset recaptures straps and clears marker
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (12) @(posedge clk_i);
        rd_chk(12'h000, exp_word(4'h0, 4'h7, 3'h2), "refresh");
        chk("join_strap_o", 32'h0000_0002, {29'h0, join_strap_o});
        summarize();
    end

endmodule // test_switch_status_upper_fields
`default_nettype wire
